// ---- tb/ddr_io_cell_sva.sv ----
// Port checker for the dual-edge I/O cell.
module ddr_io_cell_sva #(parameter ADDR_W = 12) (input wire logic sys_clk, rst, psel, penable,
   input wire logic pwrite, input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   input wire logic pready, pslverr, linkClk, padIn, padOut, padOe);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy) else $error("late ready");
   property p_one; pready |=> !pready; endproperty
   a_one: assert property (p_one) else $error("long ready");
   property p_err; pready |-> pslverr == (|paddr[ADDR_W-1:4] || |paddr[1:0]); endproperty
   a_err: assert property (p_err) else $error("error flag wrong");
   property p_sle; pslverr |-> pready; endproperty
   a_sle: assert property (p_sle) else $error("stray error");
   property p_zero; !pready || pslverr |-> prdata == 32'h0000_0000; endproperty
   a_zero: assert property (p_zero) else $error("stray read data");
   property p_cmd; pready && !pwrite && paddr == 12'h00C |-> prdata == 32'h0000_0000; endproperty
   a_cmd: assert property (p_cmd) else $error("command reads back");
   property p_stat; $stable(linkClk) [*7] ##0 (pready && !pwrite && paddr == 12'h008)
      |-> prdata[6] == linkClk; endproperty
   a_stat: assert property (p_stat) else $error("link level wrong");
   property p_hold; (!psel && $stable(linkClk)) [*7] |-> $stable({padOut, padOe}); endproperty
   a_hold: assert property (p_hold) else $error("pad moved");
   cover property (pready && pslverr);
   cover property (pready && pwrite);
   cover property (pready && !pwrite && !pslverr);
endmodule
bind ddr_io_cell ddr_io_cell_sva #(.ADDR_W(ADDR_W)) u_sva (.*);

// ---- tb/ddr_link_partner.sv ----
// Far-side model: link clock and pad data stream.
module ddr_link_partner (input wire logic run, input wire logic [1:0] bits,
   output logic linkClk = 1'b0, output logic padIn = 1'b0);
   timeunit 1ns;
   timeprecision 100ps;
   // Idle data toggles so a stale level never passes for a capture.
   initial forever begin
      #40 padIn = run ? bits[0] : ~padIn;
      #40 linkClk = run;
      #40 padIn = run ? bits[1] : ~padIn;
      #40 linkClk = 1'b0;
   end
endmodule

// ---- tb/tb_ddr_io_register_pairs.sv ----
// Self-checking bench for the dual-edge I/O cell.
`include "ddr_io_defs.vh"
module tb_ddr_io_register_pairs;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [31:0] ZERO = 32'h0000_0000;
   localparam logic [32:0] FULL = 33'h1_FFFF_FFFF, NONE = 33'h0_0000_0000;
   logic sys_clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic run = 1'b0, pready, pslverr, linkClk, padIn, padOut, padOe;
   logic [1:0] bits = 2'h0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = ZERO, prdata, seed = 32'h1c2c_fb3c;
   logic [5:0] elems = 6'h00;
   int failures = 0, n_checks = 0, cyc = 0;
   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) cyc <= cyc + 1;
   always @(posedge sys_clk) if (cyc == 20000) report_and_stop;
   ddr_io_cell i_dut (.*);
   ddr_link_partner i_far (.*);
   function automatic logic [31:0] lfsr(logic [31:0] x);
      return {x[30:0], 1'b0} ^ (x[31] ? 32'h0040_0007 : ZERO);
   endfunction
   function automatic logic [5:0] next6(logic [5:0] o, s, logic h);
      return {s[5:2], h ? o[1:0] : s[1:0]};
   endfunction
   task automatic chk(logic [32:0] got, logic [32:0] exp);
      n_checks++;
      if (got !== exp) failures++;
      if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
   endtask
   task automatic report_and_stop;
      if (cyc >= 20000) failures++;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, logic [32:0] m, x);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      if (m !== NONE) chk({pslverr, prdata} & m, x);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      apb(1'b0, `DDR_ADDR_CTRL, ZERO, FULL, 33'h0_0000_0007);
      apb(1'b0, 12'h010, ZERO, FULL, 33'h1_0000_0000);
      run <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         seed = lfsr(seed);
         bits <= seed[5:4];
         apb(1'b1, `DDR_ADDR_CTRL, i == 4 ? 32'h0000_0006 : 32'h0000_0007, NONE, NONE);
         apb(1'b1, `DDR_ADDR_DATA, seed & 32'h0000_000F, NONE, NONE);
         elems = next6(elems, seed[5:0], i == 4);
         repeat (3) @(posedge linkClk);
         #40 chk({padOe, padOut}, {elems[3], elems[1]});
         @(negedge linkClk);
         #40 chk({padOe, padOut}, {elems[2], elems[0]});
         apb(1'b0, `DDR_ADDR_STATUS, ZERO, 33'h3F, {27'h000_0000, elems});
      end
      for (int k = 0; k < 3; k++) begin
         apb(1'b1, `DDR_ADDR_CTRL, k == 0 ? 32'h0000_150F :
             (k == 1 ? 32'h0000_000F : 32'h0000_0217), NONE, NONE);
         apb(1'b0, `DDR_ADDR_STATUS, ZERO, 33'h3F, {27'h000_0000, {6{k != 1}}});
      end
      run <= 1'b0;
      apb(1'b1, `DDR_ADDR_CTRL, 32'h003D_0007, NONE, NONE);
      repeat (20) @(posedge sys_clk);
      apb(1'b1, `DDR_ADDR_CMD, 32'h0000_0001, NONE, NONE);
      apb(1'b0, `DDR_ADDR_STATUS, ZERO, 33'h7F, 33'h0_0000_003C);
      report_and_stop;
   end
endmodule

// ---- verilog/ddr_io_cell.v ----
// Dual-edge output, output-enable and input register pairs of one I/O cell behind APB.
//
// Functional notes
// - Output pair registers joined by selecting multiplexer.
// - Output launches data on both link edges.
// - Pair registers update on opposite clock halves.
// - Enable pair forms dual-edge flop likewise.
// - Input registers clocked by true, inverted clock.
// - Input registers alternately capture successive bits.
// - One set/reset and reverse line for six.
// - Upper register polarity applies to whole pair.
// - Either initial zero forces pair to zero.
// - One clock-enable line per register pair.
`include "ddr_io_defs.vh"

// Register map, one aligned 32-bit word each.
//   Control, offset 0x000, read/write:
//     bits 2:0   clock enable of the output, enable and input pair, set after reset.
//     bit 3      set/reset line level; while high every pair is forced to its polarity.
//     bit 4      reverse line level; while high and bit 3 low every pair is forced to the opposite.
//     bits 13:8  polarity per element, upper at 8+2p and lower at 9+2p; only the upper
//                bit of a pair is used, one means set.
//     bits 21:16 initial value per element, same layout; a pair starts at one only
//                when both of its bits are one.
//   Data, offset 0x004, read/write:
//     bit 0      next bit launched on a rising link edge.
//     bit 1      next bit launched on a falling link edge.
//     bits 3:2   the same two bits for the pad enable.
//   Status, offset 0x008, read only, writes ignored:
//     bits 5:0   the six pair registers, output pair first.
//     bit 6      filtered link clock level.
//     bit 7      filtered pad input level.
//   Command, offset 0x00C, write only, reads return zero:
//     bit 0      writing one loads the programmed initial values into all pairs.
//   Any other address answers with an error, returns zero and changes nothing.
//
// Limitations:
//   The pads follow the link clock three to four system clocks late, so the cell
//   models the behaviour of the dual-edge pairs, not their pin timing.
//   The set/reset and reverse lines act synchronously to sys_clk; there is no
//   asynchronous variant of them.
//   Set/reset, reverse and global set/reset act on all six registers at once; the
//   per-pair clock enables do not gate them.
//   The polarity bit of a pair's lower register is stored and read back but has
//   no effect; its initial value bit is ANDed with the upper one.

module ddr_io_cell #(
   parameter ADDR_W = `DDR_ADDR_W
) (
   input  wire              sys_clk,
   input  wire              rst,
   input  wire              psel,
   input  wire              penable,
   input  wire              pwrite,
   input  wire [ADDR_W-1:0] paddr,
   input  wire [31:0]       pwdata,
   output reg  [31:0]       prdata,
   output reg               pready,
   output reg               pslverr,
   input  wire              linkClk,
   input  wire              padIn,
   output reg               padOut,
   output reg               padOe
);

   // Address match, shared by the read mux and the write decode.
   function hit;
      input [ADDR_W-1:0] addr;
      input [ADDR_W-1:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   // One step of a pair register, in falling order of priority: global set/reset,
   // set/reset line, reverse line, clocked load, hold. The lines act on every system
   // clock while high, so they still work when the link clock is stopped.
   function elemStep;
      input global_set_reset;
      input init;
      input sr;
      input reverse_line;
      input pol;
      input load;
      input d;
      input q;
      begin
         if (global_set_reset) begin
            elemStep = init;
         end else if (sr) begin
            elemStep = pol;
         end else if (reverse_line) begin
            elemStep = ~pol;
         end else if (load) begin
            elemStep = d;
         end else begin
            elemStep = q;
         end
      end
   endfunction

   reg  [`CTRL_USED_W-1:0] ctrl_r;
   reg  [`DATA_USED_W-1:0] data_r;
   reg  [`DDR_ELEMS-1:0]   elem_r;
   wire [`DDR_ELEMS-1:0]   elemNxt;
   reg                     gsr_r;

   reg                     linkS1_r;
   reg                     linkS2_r;
   reg                     linkS3_r;
   reg                     linkLevel_r;
   reg                     padS1_r;
   reg                     padS2_r;
   reg                     padS3_r;
   reg                     padLevel_r;

   wire                    linkLevelNxt;
   wire                    padLevelNxt;
   wire                    linkRise;
   wire                    linkFall;
   wire                    setResetLine;
   wire                    reverseLine;
   wire [`DDR_ELEMS-1:0]   pairD;

   wire                    setupPhase;
   wire                    accessDone;
   wire                    mapped;
   reg  [31:0]             readMux;

   // Pins come from another domain: three stages, a change counts once stages two
   // and three agree. Only stage two reads stage one.
   // The stages reset to zero, the idle level of both pins, so no false edge is
   // seen after reset.
   // Latency: a link edge is accepted on the third system clock after it; the pair
   // registers and the pads move on the fourth. Link half periods shorter than
   // two system clocks can be lost, so the link must run at least four times slower.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         linkS1_r    <= 1'b0;
         linkS2_r    <= 1'b0;
         linkS3_r    <= 1'b0;
         linkLevel_r <= 1'b0;
         padS1_r     <= 1'b0;
         padS2_r     <= 1'b0;
         padS3_r     <= 1'b0;
         padLevel_r  <= 1'b0;
      end else begin
         linkS1_r    <= linkClk;
         linkS2_r    <= linkS1_r;
         linkS3_r    <= linkS2_r;
         linkLevel_r <= linkLevelNxt;
         padS1_r     <= padIn;
         padS2_r     <= padS1_r;
         padS3_r     <= padS2_r;
         padLevel_r  <= padLevelNxt;
      end
   end

   assign linkLevelNxt = (linkS2_r == linkS3_r) ? linkS3_r : linkLevel_r;
   assign padLevelNxt  = (padS2_r == padS3_r) ? padS3_r : padLevel_r;

   // true and inverted
   // The true clock is the filtered link level, the inverted clock its complement,
   // so the upper register moves on a rise and the lower one on a fall.
   assign linkRise = linkLevelNxt & ~linkLevel_r;
   assign linkFall = ~linkLevelNxt & linkLevel_r;

   assign setResetLine = ctrl_r[`CTRL_SET_RESET_BIT];
   assign reverseLine  = ctrl_r[`CTRL_REVERSE_BIT];

   // Pair 0 drives the pad, pair 1 the pad enable, pair 2 samples the pad.
   // The pad sample goes through the same filter depth as the link clock, so the
   // bit captured on an edge is the one that stood before that edge.
   // alternate input capture
   assign pairD = {padLevelNxt, padLevelNxt, data_r};

   genvar p;
   generate
      for (p = 0; p < `DDR_PAIRS; p = p + 1) begin : gPair
         wire pairEn;
         wire pairPol;
         wire pairInit;

         assign pairEn = ctrl_r[`CTRL_PAIR_EN_LSB + p];

         assign pairPol = ctrl_r[`CTRL_POL_LSB + 2*p];

         assign pairInit = ctrl_r[`CTRL_INIT_LSB + 2*p] & ctrl_r[`CTRL_INIT_LSB + 2*p + 1];

         assign elemNxt[2*p] = elemStep(gsr_r, pairInit, setResetLine, reverseLine, pairPol,
                                        pairEn & linkRise, pairD[2*p], elem_r[2*p]);

         assign elemNxt[2*p+1] = elemStep(gsr_r, pairInit, setResetLine, reverseLine,
                                          pairPol, pairEn & linkFall, pairD[2*p+1],
                                          elem_r[2*p+1]);
      end
   endgenerate

   // Hard reset can only load a constant, so a global set/reset is queued for the
   // first edge after release and applies the programmed initial values then.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         elem_r <= {`DDR_ELEMS{1'b0}};
         gsr_r  <= 1'b1;
      end else begin
         elem_r <= elemNxt;
         gsr_r  <= accessDone & pwrite & hit(paddr, `DDR_ADDR_CMD) & pwdata[`CMD_GSR_BIT];
      end
   end

   // glitch free select
   // The mux looks at next register values so the pad never shows a stale bit for
   // a cycle after an edge. Pad timing trails the link edge by the filter depth.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         padOut <= 1'b0;
         padOe  <= 1'b0;
      end else begin
         padOut <= linkLevelNxt ? elemNxt[0] : elemNxt[1];
         padOe  <= linkLevelNxt ? elemNxt[2] : elemNxt[3];
      end
   end

   // APB slave: one wait-free access phase, pready answers in the first access cycle.
   // The setup edge latches read data and the error flag, pready stands for exactly
   // the access cycle and a write lands at its closing edge. Read data and error
   // return to zero after that edge, so a late sampler sees zero, never stale data.
   assign setupPhase = psel & ~penable;
   assign accessDone = psel & penable & pready;
   assign mapped     = hit(paddr, `DDR_ADDR_CTRL) | hit(paddr, `DDR_ADDR_DATA) |
                       hit(paddr, `DDR_ADDR_STATUS) | hit(paddr, `DDR_ADDR_CMD);

   // Reads decode the address combinationally; the setup edge registers the result,
   // which keeps prdata a flip-flop output.
   always @* begin
      readMux = 32'h0000_0000;
      if (hit(paddr, `DDR_ADDR_CTRL)) begin
         readMux[`CTRL_USED_W-1:0] = ctrl_r;
      end else if (hit(paddr, `DDR_ADDR_DATA)) begin
         readMux[`DATA_USED_W-1:0] = data_r;
      end else if (hit(paddr, `DDR_ADDR_STATUS)) begin
         readMux[`STAT_ELEM_LSB + `DDR_ELEMS - 1:`STAT_ELEM_LSB] = elem_r;
         readMux[`STAT_LINK_BIT] = linkLevel_r;
         readMux[`STAT_PAD_BIT]  = padLevel_r;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready <= setupPhase;
         if (setupPhase) begin
            pslverr <= ~mapped;
            prdata  <= pwrite ? 32'h0000_0000 : readMux;
         end else if (accessDone) begin
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
         end
      end
   end

   // Writes take effect only at the completing edge; unmapped and status writes
   // change nothing.
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_r <= `CTRL_RESET;
         data_r <= `DATA_RESET;
      end else if (accessDone & pwrite) begin
         if (hit(paddr, `DDR_ADDR_CTRL)) begin
            ctrl_r <= pwdata[`CTRL_USED_W-1:0];
         end
         if (hit(paddr, `DDR_ADDR_DATA)) begin
            data_r <= pwdata[`DATA_USED_W-1:0];
         end
      end
   end

endmodule

// ---- verilog/ddr_io_defs.vh ----
// Constants for the dual-edge I/O cell: register map, field positions and reset values.
`ifndef DDR_IO_DEFS_VH
`define DDR_IO_DEFS_VH

`define DDR_ADDR_W         12
`define DDR_ADDR_CTRL      12'h000
`define DDR_ADDR_DATA      12'h004
`define DDR_ADDR_STATUS    12'h008
`define DDR_ADDR_CMD       12'h00C

`define DDR_PAIRS          3
`define DDR_ELEMS          6

`define CTRL_PAIR_EN_LSB   0
`define CTRL_SET_RESET_BIT 3
`define CTRL_REVERSE_BIT   4
`define CTRL_POL_LSB       8
`define CTRL_INIT_LSB      16
`define CTRL_USED_W        22
`define CTRL_RESET         22'h00_0007

`define DATA_USED_W        4
`define DATA_RESET         4'h0

`define STAT_ELEM_LSB      0
`define STAT_LINK_BIT      6
`define STAT_PAD_BIT       7
`define STAT_USED_W        8

`define CMD_GSR_BIT        0

`endif
